//--- logic/spw_soft_power.sv
// soft power wake logic with wake status and management interrupt enable
//
// Notes on behaviour
// R1: wake enable two bits 0,1 enable uart receive
// R2: bit 4 enables alarm two, resets 0
// R3: bit 6 selects power good pin role
// R4: bit 7 button power off enable, resets 1
// R5: status one reports which wake event occurred
// R6: pin falling edges latch status, read clears
// R7: status one bit 7 latches rtc alarm
// R8: status bits 4,5 follow group irqs directly
// R9: status two bits 0,1 latch uart falls
// R10: status two bit 4 alarm two, read clears
// R11: button latch, read clears, no power feed
// R12: enable register routes sources onto management irq
// R13: wake enable one enables eight wake sources
// R14: power on asserted by enabled set status
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
module spw_soft_power
   import spw_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [SPW_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire spw_pins_s wake_pins,
   input wire logic uart_one_rx,
   input wire logic uart_two_rx,
   input wire logic group_irq_one,
   input wire logic group_irq_two,
   input wire logic rtc_alarm,
   input wire logic rtc_alarm_two,
   input wire logic button_press,
   input wire spw_mgmt_src_s mgmt_src,
   output logic power_on_out_n,
   output logic power_good_mode_en,
   output logic button_off_en,
   output logic mgmt_irq_out_n,
   output logic irq
);
   localparam int PIN_W = 7;

   logic [7:0] wake_en_one_reg, wake_en_one_next;
   logic [7:0] wake_en_two_reg, wake_en_two_next;
   logic [7:0] status_one_reg, status_one_next;
   logic [7:0] status_two_reg, status_two_next;
   logic [7:0] mgmt_en_reg, mgmt_en_next;
   logic [7:0] irq_status_reg, irq_status_next;
   logic [7:0] irq_mask_reg, irq_mask_next;
   logic [31:0] prdata_reg, prdata_next;
   logic power_on_reg, power_on_next;
   logic mgmt_irq_reg, mgmt_irq_next;
   logic btn_prev_reg, btn_prev_next;

   logic [PIN_W-1:0] pin_vec;
   logic [PIN_W-1:0] pin_fall;
   logic access;
   logic wr;
   logic rd;
   logic rd_setup;
   logic [7:0] idx;
   logic mapped;
   logic [7:0] wdata8;
   logic [7:0] st1_live;
   logic [7:0] st1_set;
   logic [7:0] st2_set;
   logic [7:0] wake_view_one;
   logic [7:0] wake_view_two;
   logic [7:0] wake_en_two_view;
   logic [7:0] irq_set;
   logic btn_rise;
   logic wake_any;
   logic mgmt_any;
   logic [7:0] rd_val;

   assign pin_vec = {uart_two_rx, uart_one_rx, wake_pins};

   spw_fall_det #(
      .WIDTH(PIN_W)
   ) u_fall (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(pin_vec),
      .fall(pin_fall)
   );

   // apb decode: zero wait states, word index is paddr[9:2]
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign rd = access & ~pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign idx = paddr[SPW_ADDR_W-1:2];
   assign wdata8 = pwdata[7:0];
   assign pready = 1'b1;
   assign mapped = (idx == SPW_IDX_WAKE_EN_ONE) || (idx == SPW_IDX_WAKE_EN_TWO) ||
      (idx == SPW_IDX_WAKE_STATUS_ONE) || (idx == SPW_IDX_WAKE_STATUS_TWO) ||
      (idx == SPW_IDX_MGMT_IRQ_EN_ONE) || (idx == SPW_IDX_IRQ_STATUS) ||
      (idx == SPW_IDX_IRQ_MASK);
   assign pslverr = access & ~mapped;

   // bit layout of status one: ring1, ring2, kbd, mouse, grp1, grp2, ir, alarm
   always_comb begin
      st1_set = 8'h00;
      st1_set[3:0] = pin_fall[3:0]; // R6
      st1_set[6] = pin_fall[4]; // R6
      st1_set[SPW_ST1_ALARM] = rtc_alarm; // R7
      st2_set = 8'h00;
      st2_set[1:0] = pin_fall[6:5]; // R9
      st2_set[SPW_ST2_ALARM2] = rtc_alarm_two; // R10
      st2_set[SPW_ST2_BUTTON] = btn_rise; // R11
   end

   assign btn_rise = button_press & ~btn_prev_reg;

   // unlatched group interrupt bits shown live
   always_comb begin
      st1_live = status_one_reg & SPW_ST1_LATCHED;
      st1_live[SPW_ST1_GRP1] = group_irq_one; // R8
      st1_live[SPW_ST1_GRP2] = group_irq_two; // R8
   end

   assign wake_en_two_view = wake_en_two_reg & SPW_EN2_WMASK;

   always_comb begin
      case (idx)
         SPW_IDX_WAKE_EN_ONE: rd_val = wake_en_one_reg;
         SPW_IDX_WAKE_EN_TWO: rd_val = wake_en_two_view;
         SPW_IDX_WAKE_STATUS_ONE: rd_val = st1_live; // R5
         SPW_IDX_WAKE_STATUS_TWO: rd_val = status_two_reg;
         SPW_IDX_MGMT_IRQ_EN_ONE: rd_val = mgmt_en_reg;
         SPW_IDX_IRQ_STATUS: rd_val = irq_status_reg;
         SPW_IDX_IRQ_MASK: rd_val = irq_mask_reg;
         default: rd_val = 8'h00;
      endcase
   end

   // configuration registers
   always_comb begin
      wake_en_one_next = wake_en_one_reg;
      wake_en_two_next = wake_en_two_reg;
      mgmt_en_next = mgmt_en_reg;
      irq_mask_next = irq_mask_reg;
      if (wr) begin
         case (idx)
            SPW_IDX_WAKE_EN_ONE: wake_en_one_next = wdata8; // R13
            SPW_IDX_WAKE_EN_TWO: wake_en_two_next = wdata8 & SPW_EN2_WMASK; // R1
            SPW_IDX_MGMT_IRQ_EN_ONE: mgmt_en_next = wdata8; // R12
            SPW_IDX_IRQ_MASK: irq_mask_next = wdata8 & SPW_IRQ_USED;
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_en_one_reg <= SPW_WAKE_EN_ONE_RST;
         wake_en_two_reg <= SPW_WAKE_EN_TWO_RST; // R2 R3 R4
         mgmt_en_reg <= SPW_MGMT_EN_RST;
         irq_mask_reg <= SPW_IRQ_MASK_RST;
      end else begin
         wake_en_one_reg <= wake_en_one_next;
         wake_en_two_reg <= wake_en_two_next;
         mgmt_en_reg <= mgmt_en_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   // sticky status: a read clears only the bits it showed, so an event that
   // lands between the setup snapshot and the access edge is kept; a set wins
   always_comb begin
      status_one_next = status_one_reg;
      status_two_next = status_two_reg;
      irq_status_next = irq_status_reg;
      if (rd && idx == SPW_IDX_WAKE_STATUS_ONE) begin
         status_one_next = status_one_reg & ~prdata_reg[7:0]; // R6 R7
      end
      if (rd && idx == SPW_IDX_WAKE_STATUS_TWO) begin
         status_two_next = status_two_reg & ~prdata_reg[7:0]; // R9 R10 R11
      end
      if (rd && idx == SPW_IDX_IRQ_STATUS) begin
         irq_status_next = irq_status_reg & ~prdata_reg[7:0];
      end
      status_one_next = (status_one_next | st1_set) & SPW_ST1_LATCHED;
      status_two_next = status_two_next | st2_set;
      irq_status_next = (irq_status_next | irq_set) & SPW_IRQ_USED;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_one_reg <= SPW_STATUS_RST;
         status_two_reg <= SPW_STATUS_RST;
         irq_status_reg <= SPW_STATUS_RST;
      end else begin
         status_one_reg <= status_one_next;
         status_two_reg <= status_two_next;
         irq_status_reg <= irq_status_next;
      end
   end

   // wake decision: group irqs count live, button latch excluded
   always_comb begin
      wake_view_one = st1_live & wake_en_one_reg; // R13 R14
      wake_view_two = 8'h00;
      wake_view_two[0] = status_two_reg[0] & wake_en_two_reg[SPW_EN2_UART1]; // R1
      wake_view_two[1] = status_two_reg[1] & wake_en_two_reg[SPW_EN2_UART2]; // R1
      wake_view_two[4] = status_two_reg[SPW_ST2_ALARM2] & wake_en_two_reg[SPW_EN2_ALARM2]; // R2
      wake_view_two = wake_view_two & SPW_ST2_POWER; // R11
   end

   assign wake_any = |{wake_view_one, wake_view_two}; // R14
   assign mgmt_any = |(mgmt_src & mgmt_en_reg); // R12

   always_comb begin
      irq_set = 8'h00;
      irq_set[SPW_IRQ_WAKE] = wake_any & ~power_on_reg;
      irq_set[SPW_IRQ_BUTTON] = btn_rise;
      irq_set[SPW_IRQ_MGMT] = mgmt_any & ~mgmt_irq_reg;
   end

   // output and read data registers
   always_comb begin
      power_on_next = wake_any; // R14
      mgmt_irq_next = mgmt_any; // R12
      btn_prev_next = button_press;
      prdata_next = prdata_reg;
      if (rd_setup) begin
         prdata_next = {24'h000000, rd_val};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_on_reg <= 1'b0;
         mgmt_irq_reg <= 1'b0;
         btn_prev_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         power_on_reg <= power_on_next;
         mgmt_irq_reg <= mgmt_irq_next;
         btn_prev_reg <= btn_prev_next;
         prdata_reg <= prdata_next;
      end
   end

   // read data is captured at the setup edge, so it comes from a flop and
   // still stands in the zero-wait access cycle; live group bits are one cycle old
   assign prdata = prdata_reg;
   assign power_on_out_n = ~power_on_reg; // R14
   assign power_good_mode_en = wake_en_two_reg[SPW_EN2_PG]; // R3
   assign button_off_en = wake_en_two_reg[SPW_EN2_OFF]; // R4
   assign mgmt_irq_out_n = ~mgmt_irq_reg; // R12
   assign irq = |(irq_status_reg & irq_mask_reg);
endmodule

//--- logic/spw_pkg.sv
// package for the soft power wake and management interrupt enable block
package spw_pkg;
   // register offsets: printed offsets are not multiples of four, so they are indices
   localparam logic [7:0] SPW_IDX_WAKE_EN_ONE = 8'hB0;
   localparam logic [7:0] SPW_IDX_WAKE_EN_TWO = 8'hB1;
   localparam logic [7:0] SPW_IDX_WAKE_STATUS_ONE = 8'hB2;
   localparam logic [7:0] SPW_IDX_WAKE_STATUS_TWO = 8'hB3;
   localparam logic [7:0] SPW_IDX_MGMT_IRQ_EN_ONE = 8'hB4;
   localparam logic [7:0] SPW_IDX_IRQ_STATUS = 8'hC0;
   localparam logic [7:0] SPW_IDX_IRQ_MASK = 8'hC1;
   localparam int SPW_ADDR_W = 10;
   // reset values
   localparam logic [7:0] SPW_WAKE_EN_ONE_RST = 8'h00;
   localparam logic [7:0] SPW_WAKE_EN_TWO_RST = 8'h80;
   localparam logic [7:0] SPW_STATUS_RST = 8'h00;
   localparam logic [7:0] SPW_MGMT_EN_RST = 8'h00;
   localparam logic [7:0] SPW_IRQ_MASK_RST = 8'h00;
   // wake enable two fields
   localparam int SPW_EN2_UART1 = 0;
   localparam int SPW_EN2_UART2 = 1;
   localparam int SPW_EN2_ALARM2 = 4;
   localparam int SPW_EN2_PG = 6;
   localparam int SPW_EN2_OFF = 7;
   localparam logic [7:0] SPW_EN2_WMASK = 8'hD3;
   // wake status one fields
   localparam int SPW_ST1_GRP1 = 4;
   localparam int SPW_ST1_GRP2 = 5;
   localparam int SPW_ST1_ALARM = 7;
   localparam logic [7:0] SPW_ST1_LATCHED = 8'hCF;
   // wake status two fields
   localparam int SPW_ST2_BUTTON = 2;
   localparam int SPW_ST2_ALARM2 = 4;
   localparam logic [7:0] SPW_ST2_POWER = 8'h13;
   // interrupt status/mask fields
   localparam int SPW_IRQ_WAKE = 0;
   localparam int SPW_IRQ_BUTTON = 1;
   localparam int SPW_IRQ_MGMT = 2;
   localparam logic [7:0] SPW_IRQ_USED = 8'h07;

   // falling-edge pin inputs, one bit per wake pin
   typedef struct packed {
      logic ir_rx_two;
      logic mouse_clk;
      logic keyboard_clk;
      logic ring_two;
      logic ring_one;
   } spw_pins_s;

   // internal device interrupt sources, bit order matches the enable register
   typedef struct packed {
      logic watchdog;
      logic group_one;
      logic group_two;
      logic floppy;
      logic uart_one;
      logic uart_two;
      logic parallel;
      logic disk_iface;
   } spw_mgmt_src_s;
endpackage

//--- logic/spw_fall_det.sv
// falling edge detector bank for wake pins
`timescale 1ns/1ns
module spw_fall_det
   import spw_pkg::*;
#(
   parameter int WIDTH = 7
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] prev_reg;
   logic [WIDTH-1:0] prev_next;

   always_comb begin
      prev_next = pin_in;
   end

   // idle pins sit high, so a reset value of ones avoids a false edge at release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= '1;
      end else begin
         prev_reg <= prev_next;
      end
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_fall
         assign fall[i] = prev_reg[i] & ~pin_in[i];
      end
   endgenerate
endmodule

//--- sim/spw_soft_power_assertions.sv
// port-level assertions for the soft power wake block
`timescale 1ns/1ns
module spw_soft_power_assertions
   import spw_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [SPW_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic group_irq_one,
   input wire logic group_irq_two,
   input wire spw_mgmt_src_s mgmt_src,
   input wire logic power_good_mode_en,
   input wire logic button_off_en,
   input wire logic mgmt_irq_out_n
);
   wire wr_acc = psel && penable && pwrite;
   wire rd_acc = psel && penable && !pwrite;
   wire [7:0] ix = paddr[9:2];
   // shadow of the enable register, loaded at the same edge as the design's copy
   logic [7:0] en_q;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) en_q <= 8'h00;
      else if (wr_acc && ix == SPW_IDX_MGMT_IRQ_EN_ONE) en_q <= pwdata[7:0];
   sequence s_rd(logic [7:0] i); psel && !penable && !pwrite && ix == i ##1 rd_acc; endsequence
   sequence s_wr2; wr_acc && ix == SPW_IDX_WAKE_EN_TWO; endsequence
   property p_off_wr; s_wr2 |=> button_off_en == $past(pwdata[7]); endproperty
   a_off_wr: assert property (p_off_wr) else $error("off enable not written");
   property p_pg_wr; s_wr2 |=> power_good_mode_en == $past(pwdata[6]); endproperty
   a_pg_wr: assert property (p_pg_wr) else $error("power good mode not written");
   property p_off_hold; !$past(wr_acc) |-> $stable(button_off_en); endproperty
   a_off_hold: assert property (p_off_hold) else $error("off enable moved alone");
   property p_pg_hold; !$past(wr_acc) |-> $stable(power_good_mode_en); endproperty
   a_pg_hold: assert property (p_pg_hold) else $error("power good mode moved alone");
   property p_mgmt; mgmt_irq_out_n == !(|($past(mgmt_src) & $past(en_q))); endproperty
   a_mgmt: assert property (p_mgmt) else $error("mgmt irq mismatch");
   property p_grp;
      s_rd(SPW_IDX_WAKE_STATUS_ONE) ##0 $stable(group_irq_one) && $stable(group_irq_two)
         |-> prdata[5:4] == {group_irq_two, group_irq_one};
   endproperty
   a_grp: assert property (p_grp) else $error("group status not live");
   property p_upper; rd_acc |-> prdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_en2_rsv; s_rd(SPW_IDX_WAKE_EN_TWO) |-> !prdata[5] && prdata[3:2] == 2'h0; endproperty
   a_en2_rsv: assert property (p_en2_rsv) else $error("enable two reserved set");
   property p_st2_rsv; s_rd(SPW_IDX_WAKE_STATUS_TWO) |-> prdata[7:5] == 3'h0 && !prdata[3];
   endproperty
   a_st2_rsv: assert property (p_st2_rsv) else $error("status two reserved set");
endmodule

//--- sim/spw_src_model.sv
// wake sources: pins idle high, alarms and button idle low, one-cycle events
`timescale 1ns/1ns
module spw_src_model
   import spw_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] ev,
   input wire logic go,
   output spw_pins_s wake_pins,
   output logic uart_one_rx,
   output logic uart_two_rx,
   output logic rtc_alarm,
   output logic rtc_alarm_two,
   output logic button_press
);
   logic [9:0] q = 10'h000;
   always @(posedge pclk or negedge presetn)
      if (!presetn) q <= 10'h000;
      else q <= go ? 10'h001 << ev : 10'h000;
   assign wake_pins = ~q[4:0];
   assign rtc_alarm = q[5];
   assign uart_one_rx = ~q[6];
   assign uart_two_rx = ~q[7];
   assign rtc_alarm_two = q[8];
   assign button_press = q[9];
endmodule

//--- sim/testbench.sv
// self-checking bench for the soft power wake block
`timescale 1ns/1ns
module testbench
   import spw_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, irq;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic uart_one_rx, uart_two_rx, group_irq_one, group_irq_two, rtc_alarm, rtc_alarm_two;
   logic button_press, power_on_out_n, power_good_mode_en, button_off_en, mgmt_irq_out_n;
   logic [3:0] ev;
   logic [15:0] rnd;
   logic err;
   spw_pins_s wake_pins;
   spw_mgmt_src_s mgmt_src;
   int n_errors = 0;
   int n_compared = 0;
   int st[2] = '{0, 0};
   int bm[10] = '{0, 1, 2, 3, 6, 7, 0, 1, 4, 2};
   logic [7:0] rix[7] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hC0, 8'hC1};
   logic [7:0] rrv[7] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   spw_soft_power spw_soft_power_i (.*);
   spw_src_model spw_src_model_i (.*);
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin
         n_errors++;
         $display("wrong value at %0t seen %h expected %h", $time, s, x);
      end
   endtask
   // one idle cycle after each transfer keeps psel from being assigned twice per step
   task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] x);
      apb(0, i, 8'h00);
      chk(rdv, {24'h0, x});
   endtask
   task automatic complete_run;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      pclk = 0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      repeat (5000) @(posedge pclk);
      n_errors++;
      complete_run;
   end
   initial begin
      {presetn, psel, penable, pwrite, go, group_irq_one, group_irq_two} = 0;
      {paddr, pwdata, ev, mgmt_src} = 0;
      rnd = 16'd5118;
      repeat (10) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      for (int i = 0; i < 7; i++) rd(rix[i], rrv[i]);
      chk({button_off_en, power_good_mode_en, power_on_out_n}, 3'h5);
      apb(1, SPW_IDX_WAKE_EN_TWO, 8'hFF);
      rd(SPW_IDX_WAKE_EN_TWO, 8'hD3);
      chk({button_off_en, power_good_mode_en}, 2'h3);
      apb(1, SPW_IDX_WAKE_EN_TWO, 8'h13);
      chk({button_off_en, power_good_mode_en}, 2'h0);
      apb(1, SPW_IDX_WAKE_EN_ONE, 8'hFF);
      rd(SPW_IDX_WAKE_EN_ONE, 8'hFF);
      apb(0, 8'hFF, 8'h00);
      chk({31'h0, err}, 32'h1);
      chk(rdv, 32'h0);
      for (int k = 0; k < 10; k++) begin
         ev <= k[3:0];
         go <= 1;
         @(posedge pclk);
         go <= 0;
         repeat (4) @(posedge pclk);
         chk(power_on_out_n, k == 9);
         st[k > 5] = st[k > 5] | (1 << bm[k]);
         rd(k > 5 ? SPW_IDX_WAKE_STATUS_TWO : SPW_IDX_WAKE_STATUS_ONE, st[k > 5][7:0]);
         st[k > 5] = 0;
         rd(k > 5 ? SPW_IDX_WAKE_STATUS_TWO : SPW_IDX_WAKE_STATUS_ONE, 8'h00);
         chk(power_on_out_n, 1);
      end
      for (int j = 0; j < 4; j++) begin
         rnd = lfsr(rnd);
         apb(1, SPW_IDX_MGMT_IRQ_EN_ONE, rnd[7:0]);
         mgmt_src <= rnd[15:8];
         group_irq_one <= rnd[0];
         group_irq_two <= rnd[1];
         rd(SPW_IDX_WAKE_STATUS_ONE, {rnd[1:0], 4'h0});
         rd(SPW_IDX_WAKE_STATUS_ONE, {rnd[1:0], 4'h0});
         chk(mgmt_irq_out_n, !(|(rnd[7:0] & rnd[15:8])));
      end
      mgmt_src <= 0;
      {group_irq_one, group_irq_two} <= 0;
      apb(0, SPW_IDX_IRQ_STATUS, 8'h00);
      apb(1, SPW_IDX_IRQ_MASK, 8'h00);
      ev <= 4'd9;
      go <= 1;
      @(posedge pclk);
      go <= 0;
      repeat (4) @(posedge pclk);
      chk(irq, 0);
      apb(1, SPW_IDX_IRQ_MASK, 8'h02);
      chk(irq, 1);
      rd(SPW_IDX_IRQ_STATUS, 8'h02);
      chk(irq, 0);
      complete_run;
   end
endmodule
bind spw_soft_power spw_soft_power_assertions spw_chk_i (.*);
